// file: rtl/otl_consts.svh
// Constants of the overtravel limit handler: offsets, fields, resets, codes.
// Assumes inclusion by the package only; the top module uses its macros.
// Function
// [RQ1] Force stop when axis trips a limit
// [RQ2] Forward input off prohibits forward running
// [RQ3] Reverse input off prohibits reverse running
// [RQ4] Opposite-direction reference still accepted during overtravel
// [RQ5] Forward enable field uses or ignores input
// [RQ6] Reverse enable field uses or ignores input
// [RQ7] Stop choices: brake-hold, brake-coast, coast
// [RQ8] Decelerate with stop torque, then clamp/coast
// [RQ9] Torque control: no deceleration, coast after stop
// [RQ10] Stop torque 0..800 percent, default 800
// [RQ11] Applied stop torque clipped to motor maximum
// [RQ12] Latch warning on overtravel while powered
// [RQ13] Warning detection field, default off, immediate
// [RQ14] Warn only for reference-direction overtravel
// [RQ15] No reference: warn for either direction
// [RQ16] No warning while motor power off
// [RQ17] No warning at power-on with existing overtravel
// [RQ18] Clear command clears; rearm needs fresh overtravel
// [RQ19] Software limit overtravel also warns
// [RQ20] Warning never alters stopping or commands
// [RQ21] Host reads back position after warning; no position is held, the status register at 0x18 returns only flags
// [RQ22] Synchronise both limit inputs first
`ifndef OTL_CONSTS_SVH
`define OTL_CONSTS_SVH

// Register byte offsets
`define OTL_FWD_CFG_OFS     8'h00
`define OTL_REV_CFG_OFS     8'h04
`define OTL_STOP_CFG_OFS    8'h08
`define OTL_TORQ_CFG_OFS    8'h0c
`define OTL_WARN_CFG_OFS    8'h10
`define OTL_CTRL_OFS        8'h14
`define OTL_STATUS_OFS      8'h18

// Reset values
`define OTL_FWD_CFG_RST     16'h1000
`define OTL_REV_CFG_RST     16'h0002
`define OTL_STOP_CFG_RST    16'h0000
`define OTL_TORQ_CFG_RST    10'h320
`define OTL_WARN_CFG_RST    16'h0000

// Field codes
`define OTL_LIMIT_OFF       4'h8
`define OTL_WARN_ON         4'h1
`define OTL_STOP_COAST      4'h2
`define OTL_STOP_DB_COAST   4'h1
`define OTL_DECEL_CLAMP     4'h1
`define OTL_TORQ_MAX        10'h320

// Control bits
`define OTL_CTRL_RESTART    0
`define OTL_CTRL_WCLR       1

// AXI responses
`define OTL_RESP_OKAY       2'h0
`define OTL_RESP_SLVERR     2'h2

`endif

// file: rtl/otl_pkg.sv
// Types of the overtravel limit handler.
// Assumes the constants header is on the include path.
package otl_pkg;
    `include "otl_consts.svh"

    typedef enum logic [1:0] {
        OTL_DIR_NONE,
        OTL_DIR_FWD,
        OTL_DIR_REV
    } otl_dir_t;

    typedef enum logic [1:0] {
        OTL_ST_RUN,
        OTL_ST_BRAKE,
        OTL_ST_HOLD
    } otl_state_t;
endpackage : otl_pkg

// file: rtl/otl_top.sv
// Overtravel limit handler: limit inputs, stop method, warning, AXI4-Lite.
// Assumes limit pins are asynchronous; other inputs share aclk.
`timescale 1ns/1ps

module otl_top (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    // Limit switch pins
    input  wire logic             fwd_limit_in,
    input  wire logic             rev_limit_in,
    // Drive state
    input  wire logic             servo_on,
    input  wire logic             torque_mode,
    input  wire logic             motor_stopped,
    input  wire otl_pkg::otl_dir_t ref_dir,
    input  wire logic             soft_fwd_limit,
    input  wire logic             soft_rev_limit,
    input  wire logic [9:0]       max_torque,
    input  wire logic             warn_clear_cmd,
    // Motion control
    output logic                  fwd_inhibit,
    output logic                  rev_inhibit,
    output logic                  dynamic_brake,
    output logic                  coast,
    output logic                  decel_stop,
    output logic                  zero_clamp,
    output logic [9:0]            estop_torque,
    output logic                  overtravel_warning
);
    import otl_pkg::*;

    // ********************************************************
    // Functions
    // ********************************************************
    function automatic logic [15:0] otl_merge(input logic [15:0] old_val,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
        logic [15:0] res;
        res = old_val;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction : otl_merge

    function automatic logic [9:0] otl_min(input logic [9:0] a,
                                           input logic [9:0] b);
        return (a < b) ? a : b;
    endfunction : otl_min

    // ********************************************************
    // Declarations
    // ********************************************************
    logic        fwd_meta_reg;
    logic        fwd_sync_reg;
    logic        rev_meta_reg;
    logic        rev_sync_reg;
    logic        aw_hold_reg;
    logic        w_hold_reg;
    logic [7:0]  waddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic [15:0] fwd_cfg_reg;
    logic [15:0] rev_cfg_reg;
    logic [15:0] stop_cfg_reg;
    logic [15:0] fwd_act_reg;
    logic [15:0] rev_act_reg;
    logic [15:0] stop_act_reg;
    logic [9:0]  torq_cfg_reg;
    logic [15:0] warn_cfg_reg;
    logic        fwd_ot_q_reg;
    logic        rev_ot_q_reg;
    logic        servo_q_reg;
    logic        stop_fwd_reg;
    otl_state_t  state_reg;
    otl_state_t  state_next;
    logic        aw_take;
    logic        w_take;
    logic        do_write;
    logic        bvalid_next;
    logic        aw_hold_next;
    logic        w_hold_next;
    logic        ar_take;
    logic        rvalid_next;
    logic        wr_ctrl;
    logic        restart;
    logic        sw_clear;
    logic        fwd_ot;
    logic        rev_ot;
    logic        decel_sel;
    logic        warn_set;
    logic        stop_trig;
    logic        hold_exit;
    logic [9:0]  torq_wr;

    // ********************************************************
    // Limit input synchronisers
    // ********************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fwd_meta_reg <= 1'b1;
            fwd_sync_reg <= 1'b1;
            rev_meta_reg <= 1'b1;
            rev_sync_reg <= 1'b1;
        end else begin
            fwd_meta_reg <= fwd_limit_in;   // [RQ22]
            fwd_sync_reg <= fwd_meta_reg;   // [RQ22]
            rev_meta_reg <= rev_limit_in;   // [RQ22]
            rev_sync_reg <= rev_meta_reg;   // [RQ22]
        end
    end

    // ********************************************************
    // AXI4-Lite write channel
    // ********************************************************
    assign aw_take      = s_axi_awready & s_axi_awvalid;
    assign w_take       = s_axi_wready & s_axi_wvalid;
    assign do_write     = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
    assign bvalid_next  = do_write | (s_axi_bvalid & ~s_axi_bready);
    assign aw_hold_next = ~do_write & (aw_hold_reg | aw_take);
    assign w_hold_next  = ~do_write & (w_hold_reg | w_take);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg   <= 1'b0;
            w_hold_reg    <= 1'b0;
            waddr_reg     <= 8'h00;
            wdata_reg     <= 32'h0000_0000;
            wstrb_reg     <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `OTL_RESP_OKAY;
        end else begin
            aw_hold_reg   <= aw_hold_next;
            w_hold_reg    <= w_hold_next;
            s_axi_awready <= ~aw_hold_next & ~bvalid_next;
            s_axi_wready  <= ~w_hold_next & ~bvalid_next;
            s_axi_bvalid  <= bvalid_next;
            if (aw_take) begin
                waddr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                unique case (waddr_reg)
                    `OTL_FWD_CFG_OFS, `OTL_REV_CFG_OFS, `OTL_STOP_CFG_OFS,
                    `OTL_TORQ_CFG_OFS, `OTL_WARN_CFG_OFS, `OTL_CTRL_OFS,
                    `OTL_STATUS_OFS: s_axi_bresp <= `OTL_RESP_OKAY;
                    default:         s_axi_bresp <= `OTL_RESP_SLVERR;
                endcase
            end
        end
    end

    assign wr_ctrl  = do_write & (waddr_reg == `OTL_CTRL_OFS) & wstrb_reg[0];
    assign restart  = wr_ctrl & wdata_reg[`OTL_CTRL_RESTART];
    assign sw_clear = wr_ctrl & wdata_reg[`OTL_CTRL_WCLR];
    // Out-of-range torque settings saturate at the top of the range
    assign torq_wr  = (wdata_reg[15:10] != 6'h00) ? `OTL_TORQ_MAX
                    : otl_min(wdata_reg[9:0], `OTL_TORQ_MAX);  // [RQ10]

    // ********************************************************
    // Configuration registers
    // ********************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fwd_cfg_reg  <= `OTL_FWD_CFG_RST;
            rev_cfg_reg  <= `OTL_REV_CFG_RST;
            stop_cfg_reg <= `OTL_STOP_CFG_RST;
            torq_cfg_reg <= `OTL_TORQ_CFG_RST;     // [RQ10]
            warn_cfg_reg <= `OTL_WARN_CFG_RST;     // [RQ13]
        end else if (do_write) begin
            unique case (waddr_reg)
                `OTL_FWD_CFG_OFS:
                    fwd_cfg_reg <= otl_merge(fwd_cfg_reg, wdata_reg, wstrb_reg);
                `OTL_REV_CFG_OFS:
                    rev_cfg_reg <= otl_merge(rev_cfg_reg, wdata_reg, wstrb_reg);
                `OTL_STOP_CFG_OFS:
                    stop_cfg_reg <= otl_merge(stop_cfg_reg, wdata_reg, wstrb_reg);
                `OTL_TORQ_CFG_OFS: begin
                    if (wstrb_reg[1:0] == 2'h3) begin
                        torq_cfg_reg <= torq_wr;   // [RQ10]
                    end
                end
                `OTL_WARN_CFG_OFS:
                    warn_cfg_reg <= otl_merge(warn_cfg_reg, wdata_reg, wstrb_reg);
                default: ;
            endcase
        end
    end

    // Restart-class settings only reach the logic on a restart
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fwd_act_reg  <= `OTL_FWD_CFG_RST;
            rev_act_reg  <= `OTL_REV_CFG_RST;
            stop_act_reg <= `OTL_STOP_CFG_RST;
        end else if (restart) begin
            fwd_act_reg  <= fwd_cfg_reg;    // [RQ5]
            rev_act_reg  <= rev_cfg_reg;    // [RQ6]
            stop_act_reg <= stop_cfg_reg;   // [RQ7]
        end
    end

    // ********************************************************
    // AXI4-Lite read channel
    // ********************************************************
    assign ar_take     = s_axi_arready & s_axi_arvalid;
    assign rvalid_next = ar_take | (s_axi_rvalid & ~s_axi_rready);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `OTL_RESP_OKAY;
        end else begin
            s_axi_arready <= ~rvalid_next;
            s_axi_rvalid  <= rvalid_next;
            if (ar_take) begin
                s_axi_rresp <= `OTL_RESP_OKAY;
                unique case (s_axi_araddr)
                    `OTL_FWD_CFG_OFS:  s_axi_rdata <= {16'h0000, fwd_cfg_reg};
                    `OTL_REV_CFG_OFS:  s_axi_rdata <= {16'h0000, rev_cfg_reg};
                    `OTL_STOP_CFG_OFS: s_axi_rdata <= {16'h0000, stop_cfg_reg};
                    `OTL_TORQ_CFG_OFS: s_axi_rdata <= {22'h000000, torq_cfg_reg};
                    `OTL_WARN_CFG_OFS: s_axi_rdata <= {16'h0000, warn_cfg_reg};
                    `OTL_CTRL_OFS:     s_axi_rdata <= 32'h0000_0000;
                    `OTL_STATUS_OFS:
                        s_axi_rdata <= {23'h000000, rev_inhibit, fwd_inhibit,
                                        zero_clamp, decel_stop, coast,
                                        dynamic_brake, overtravel_warning,
                                        rev_ot, fwd_ot};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `OTL_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // ********************************************************
    // Overtravel detection
    // ********************************************************
    assign fwd_ot = ((fwd_act_reg[15:12] != `OTL_LIMIT_OFF) & ~fwd_sync_reg)
                  | soft_fwd_limit;  // [RQ2] [RQ5] [RQ19]
    assign rev_ot = ((rev_act_reg[3:0] != `OTL_LIMIT_OFF) & ~rev_sync_reg)
                  | soft_rev_limit;  // [RQ3] [RQ6] [RQ19]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fwd_inhibit <= 1'b0;
            rev_inhibit <= 1'b0;
        end else begin
            // Only the tripped direction is blocked
            fwd_inhibit <= fwd_ot;   // [RQ2] [RQ4]
            rev_inhibit <= rev_ot;   // [RQ3] [RQ4]
        end
    end

    // ********************************************************
    // Stop sequencer
    // ********************************************************
    assign decel_sel = (stop_act_reg[7:4] != 4'h0) & ~torque_mode;  // [RQ8] [RQ9]
    assign stop_trig = (fwd_ot & (ref_dir != OTL_DIR_REV))
                     | (rev_ot & (ref_dir != OTL_DIR_FWD));         // [RQ1] [RQ4]
    assign hold_exit = stop_fwd_reg
                     ? (~fwd_ot | (ref_dir == OTL_DIR_REV))
                     : (~rev_ot | (ref_dir == OTL_DIR_FWD));        // [RQ4]

    always_comb begin
        state_next = state_reg;
        if (!servo_on) begin
            state_next = OTL_ST_RUN;
        end else begin
            unique case (state_reg)
                OTL_ST_RUN:   if (stop_trig) state_next = OTL_ST_BRAKE;    // [RQ1]
                OTL_ST_BRAKE: if (motor_stopped) state_next = OTL_ST_HOLD;
                OTL_ST_HOLD:  if (hold_exit) state_next = OTL_ST_RUN;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg    <= OTL_ST_RUN;
            stop_fwd_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_reg == OTL_ST_RUN && state_next == OTL_ST_BRAKE) begin
                stop_fwd_reg <= fwd_ot & (ref_dir != OTL_DIR_REV);
            end
        end
    end

    // Stop actions follow the state by one cycle; warning plays no part
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dynamic_brake <= 1'b0;
            coast         <= 1'b0;
            decel_stop    <= 1'b0;
            zero_clamp    <= 1'b0;
        end else begin
            dynamic_brake <= 1'b0;
            coast         <= 1'b0;
            decel_stop    <= 1'b0;
            zero_clamp    <= 1'b0;
            unique case (state_reg)
                OTL_ST_RUN: ;
                OTL_ST_BRAKE: begin
                    if (decel_sel) begin
                        decel_stop <= 1'b1;                               // [RQ8]
                    end else if (stop_act_reg[3:0] == `OTL_STOP_COAST) begin
                        coast <= 1'b1;                                    // [RQ7]
                    end else begin
                        dynamic_brake <= 1'b1;                            // [RQ7] [RQ9]
                    end
                end
                OTL_ST_HOLD: begin
                    if (decel_sel && stop_act_reg[7:4] == `OTL_DECEL_CLAMP) begin
                        zero_clamp <= 1'b1;                               // [RQ8]
                    end else if (!torque_mode && !decel_sel
                                 && stop_act_reg[3:0] == 4'h0) begin
                        dynamic_brake <= 1'b1;                            // [RQ7]
                    end else begin
                        coast <= 1'b1;                                    // [RQ7] [RQ9]
                    end
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            estop_torque <= `OTL_TORQ_CFG_RST;
        end else begin
            estop_torque <= otl_min(torq_cfg_reg, max_torque);   // [RQ10] [RQ11]
        end
    end

    // ********************************************************
    // Overtravel warning
    // ********************************************************
    // Fresh overtravel edges only, so power-on and post-clear stay quiet
    assign warn_set = (warn_cfg_reg[15:12] == `OTL_WARN_ON)              // [RQ13]
                    & servo_on & servo_q_reg                              // [RQ16] [RQ17]
                    & (((fwd_ot & ~fwd_ot_q_reg) & (ref_dir != OTL_DIR_REV))
                     | ((rev_ot & ~rev_ot_q_reg)
                        & (ref_dir != OTL_DIR_FWD)));  // [RQ12] [RQ14] [RQ15] [RQ18]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fwd_ot_q_reg       <= 1'b0;
            rev_ot_q_reg       <= 1'b0;
            servo_q_reg        <= 1'b0;
            overtravel_warning <= 1'b0;
        end else begin
            fwd_ot_q_reg <= fwd_ot;
            rev_ot_q_reg <= rev_ot;
            servo_q_reg  <= servo_on;
            if (warn_set) begin
                overtravel_warning <= 1'b1;   // [RQ12] [RQ20]
            end else if (warn_clear_cmd || sw_clear) begin
                overtravel_warning <= 1'b0;   // [RQ18]
            end
        end
    end

endmodule : otl_top

// file: tb/otl_switches.sv
// Limit switch model: normally closed contacts that open when tripped.
// Assumes trip requests come from the bench; contact edges land off the clock grid.
`timescale 1ns/1ps

module otl_switches (
    // Trip requests
    input  wire logic fwd_trip,
    input  wire logic rev_trip,
    // Contacts, high while travel is allowed
    output wire logic fwd_limit_in,
    output wire logic rev_limit_in
);
    assign #7 fwd_limit_in = !fwd_trip;
    assign #9 rev_limit_in = !rev_trip;
endmodule : otl_switches

// file: tb/otl_asserts.sv
// Concurrent checks on the overtravel handler ports.
// Assumes binding into otl_top; configuration registers are not visible here.
`timescale 1ns/1ps

module otl_asserts (
    // Clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // Watched ports
    input wire logic       s_axi_bvalid,
    input wire logic       fwd_limit_in,
    input wire logic       servo_on,
    input wire logic       torque_mode,
    input wire logic       soft_fwd_limit,
    input wire logic       soft_rev_limit,
    input wire logic [9:0] max_torque,
    input wire logic       warn_clear_cmd,
    input wire logic       fwd_inhibit,
    input wire logic       rev_inhibit,
    input wire logic       decel_stop,
    input wire logic       zero_clamp,
    input wire logic [9:0] estop_torque,
    input wire logic       overtravel_warning
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_fwd_soft_inh: assert property (soft_fwd_limit [*4] |-> fwd_inhibit)
        else $error("forward not inhibited under software limit");
    a_rev_soft_inh: assert property (soft_rev_limit [*4] |-> rev_inhibit)
        else $error("reverse not inhibited under software limit");
    a_fwd_run_free: assert property ((fwd_limit_in && !soft_fwd_limit) [*4] |-> !fwd_inhibit)
        else $error("forward inhibited with limit closed");
    a_torque_clip: assert property ($stable(max_torque) [*3] |-> estop_torque <= max_torque)
        else $error("stop torque above motor maximum");
    a_torque_no_decel: assert property (torque_mode [*3] |-> !decel_stop && !zero_clamp)
        else $error("deceleration used under torque control");
    a_warn_power_off: assert property (!servo_on |=> !$rose(overtravel_warning))
        else $error("warning raised with motor power off");
    a_warn_power_on: assert property ($rose(servo_on) |=> !$rose(overtravel_warning))
        else $error("warning raised at power on");
    a_warn_sticky: assert property (overtravel_warning && !warn_clear_cmd
        |=> overtravel_warning || $rose(s_axi_bvalid)) else $error("warning dropped without clear");
endmodule : otl_asserts

bind otl_top otl_asserts u_otl_asserts (.aclk, .aresetn, .s_axi_bvalid, .fwd_limit_in,
    .servo_on, .torque_mode, .soft_fwd_limit, .soft_rev_limit, .max_torque, .warn_clear_cmd,
    .fwd_inhibit, .rev_inhibit, .decel_stop, .zero_clamp, .estop_torque, .overtravel_warning);

// file: tb/otl_top_tb_top.sv
// Self-checking bench for the overtravel handler against a behavioural model.
// Assumes the switch model and the bound checker are compiled alongside.
`timescale 1ns/1ps

module otl_top_tb_top;
    import otl_pkg::*;
    logic aclk = 0, aresetn = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, fwd_trip = 0, rev_trip = 0, servo_on = 0, torque_mode = 0;
    logic motor_stopped = 0, soft_fwd_limit = 0, soft_rev_limit = 0, warn_clear_cmd = 0;
    logic fwd_inhibit, rev_inhibit, dynamic_brake, coast, decel_stop, zero_clamp;
    logic overtravel_warning, fen = 1, ren = 1;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [9:0] max_torque = 10'h320, estop_torque;
    wire logic fwd_limit_in, rev_limit_in;
    otl_dir_t ref_dir = OTL_DIR_NONE;
    int mismatches = 0, samples_checked = 0, c, v, ph;
    int codes [5] = '{0, 1, 2, 16, 32};
    logic [31:0] rst [8] = '{32'h1000, 32'h2, 32'h0, 32'h320, 32'h0, 32'h0, 32'h0, 32'h0};

    otl_top DUT (.*);
    otl_switches u_sw (.fwd_trip, .rev_trip, .fwd_limit_in, .rev_limit_in);

    always #12.5 aclk = ~aclk;

    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_port(input logic [9:0] got, input logic [9:0] exp);
        chk_word({22'h0, got}, {22'h0, exp});
    endtask : chk_port
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
        #2;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit aw = 0, w = 0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!(aw && w)) begin
            @(posedge aclk);
            aw |= s_axi_awready;
            w |= s_axi_wready;
            s_axi_awvalid <= !aw;
            s_axi_wvalid <= !w;
        end
        while (!s_axi_bvalid) @(posedge aclk);
        rs = s_axi_bresp;
        s_axi_bready <= 0;
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (!s_axi_rvalid);
        {rd, rs} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 0;
    endtask : rdr
    // Inhibits from the applied limit enables and both limit sources
    function automatic logic [9:0] inh_exp();
        return {8'h0, ren & rev_trip | soft_rev_limit, fen & fwd_trip | soft_fwd_limit};
    endfunction : inh_exp
    // Order {dynamic_brake, coast, decel_stop, zero_clamp}
    function automatic logic [9:0] stop_exp(input int k, input bit hold);
        if (!hold) return (k > 8 && !torque_mode) ? 10'h2 : (k % 16 == 2) ? 10'h4 : 10'h8;
        if (k == 16 && !torque_mode) return 10'h1;
        return (k == 0 && !torque_mode) ? 10'h8 : 10'h4;
    endfunction : stop_exp
    task automatic step(input logic [3:0] p, input logic w);
        @(posedge aclk);
        {fwd_trip, rev_trip, soft_fwd_limit, servo_on} <= p;
        cyc(6);
        chk_port(overtravel_warning, w);
    endtask : step

    initial begin
        #200000;
        mismatches++;
        tally_and_finish;
    end

    initial begin
        void'($urandom(37936));
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        for (c = 0; c < 8; c++) begin
            rdr(8'(c * 4));
            chk_word(rd, rst[c]);
            chk_word(32'(rs), (c == 7) ? 32'h2 : 32'h0);
        end
        wr(8'h0c, 32'd900);
        chk_word(32'(rs), 32'h0);
        rdr(8'h0c);
        chk_word(rd, 32'd800);
        for (c = 0; c < 4; c++) begin
            v = (c == 3) ? 800 : $urandom % 801;
            @(posedge aclk);
            max_torque <= 10'($urandom % 801);
            wr(8'h0c, 32'(v));
            cyc(2);
            chk_port(estop_torque, 10'((v < max_torque) ? v : max_torque));
        end
        // Limit enables apply only after restart
        for (ph = 0; ph < 2; ph++) begin
            wr(8'h00, ph ? 32'h1000 : 32'h8000);
            wr(8'h04, ph ? 32'h2 : 32'h8);
            for (c = 0; c < 7; c++) begin
                if (c == 1) begin
                    wr(8'h14, 32'h1);
                    {fen, ren} = {2{ph[0]}};
                end
                @(posedge aclk);
                {fwd_trip, rev_trip, soft_fwd_limit, soft_rev_limit} <= c ? 4'($urandom) : 4'hc;
                cyc(6);
                chk_port({rev_inhibit, fwd_inhibit}, inh_exp());
            end
        end
        @(posedge aclk);
        {fwd_trip, rev_trip, soft_fwd_limit, soft_rev_limit} <= 4'h0;
        for (c = 0; c < 10; c++) begin
            wr(8'h08, 32'(codes[c % 5]));
            wr(8'h14, 32'h1);
            @(posedge aclk);
            {torque_mode, servo_on} <= {c > 4, 1'b1};
            ref_dir <= OTL_DIR_FWD;
            step(4'h9, 0);
            chk_port({dynamic_brake, coast, decel_stop, zero_clamp}, stop_exp(codes[c % 5], 0));
            @(posedge aclk);
            motor_stopped <= 1;
            cyc(4);
            chk_port({dynamic_brake, coast, decel_stop, zero_clamp}, stop_exp(codes[c % 5], 1));
            @(posedge aclk);
            ref_dir <= OTL_DIR_REV;
            cyc(4);
            chk_port({dynamic_brake, coast, decel_stop, zero_clamp, fwd_inhibit}, 10'h1);
            @(posedge aclk);
            {servo_on, fwd_trip, motor_stopped, torque_mode} <= 4'h0;
        end
        wr(8'h10, 32'h1000);
        @(posedge aclk);
        ref_dir <= OTL_DIR_FWD;
        step(4'h1, 0);
        step(4'h5, 0);
        step(4'h1, 0);
        step(4'h9, 1);
        @(posedge aclk);
        warn_clear_cmd <= 1;
        @(posedge aclk);
        warn_clear_cmd <= 0;
        step(4'h9, 0);
        step(4'h1, 0);
        @(posedge aclk);
        ref_dir <= OTL_DIR_NONE;
        step(4'h5, 1);
        wr(8'h14, 32'h2);
        step(4'h1, 0);
        step(4'h8, 0);
        step(4'h9, 0);
        step(4'h1, 0);
        @(posedge aclk);
        soft_fwd_limit <= 1;
        @(posedge aclk);
        soft_fwd_limit <= 0;
        cyc(4);
        chk_port(overtravel_warning, 1);
        rdr(8'h18);
        chk_word(rd & 32'h4, 32'h4);
        step(4'h9, 1);
        chk_port({dynamic_brake, coast, decel_stop, zero_clamp, fwd_inhibit}, 10'h5);
        tally_and_finish;
    end
endmodule : otl_top_tb_top
